// ### design/shrl_loader.sv
`timescale 1ns/1ps
// Function
// - Half duplex, never echo received characters.
// - Honour request/clear-to-send flow control.
// - Handshake lines inverted inside the device.
// - Accept seven-bit and eight-bit characters transparently.
// - Baud rate from switch positions 8,7,6.
// - Position 5 ON: upper-case C enters external control.
// - Position 4 parity enable, 3 parity sense.
// - Position 2 data bits, 1 stop bits.
// - Self-test reports switch byte, position n bit n-1.
// - Self-test sends A's, then shows received chars.
// - Dumps 8-bit, start at socket 1 address.
// - Colon-hex dumps beyond 64K; others limited 64K.
// - Send control-Z after dump end record.
// - Record starts colon, two-digit count, max 255.
// - Address, type, data digit pairs, consecutive addresses.
// - Types 00 data, 01 eof, 02 segment, 03 ignored.
// - All record bytes sum to zero modulo 256.
// - Type 02 value times sixteen forms segment base.
// - Top digit truncated to bank, low 16 in-bank.
// - 8-bit mode stores unmodified in-bank address.
// - 16-bit mode: shift right, complemented A0 on top.
// - Binary loads start at zero plus offset.
module shrl_loader
  import shrl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic        serialIn,
  output logic             serialOut,
  input  wire logic        reqToSend_n,
  output logic             clearToSend_n,
  input  wire logic [7:0]  config_switch_value,
  input  wire logic        sixteenBitMode,
  input  wire logic        binaryMode,
  input  wire logic [19:0] binaryOffset,
  input  wire logic [3:0]  bankMask,
  input  wire logic        selfTestSend,
  input  wire logic        dumpStart,
  input  wire logic        dumpHexFormat,
  input  wire logic [19:0] socket1_start_address,
  input  wire logic [19:0] dumpLength,
  output logic [7:0]       switchReport,
  output logic [7:0]       rxChar,
  output logic             rxCharValid,
  output logic             parityError,
  output logic             framingError,
  output logic             external_control_mode,
  output shrl_wr_t         ramWrite,
  output logic             ramWriteValid,
  input  wire logic        ramWriteReady,
  output logic [19:0]      dumpReadAddr,
  input  wire logic [7:0]  dumpReadData,
  output logic             dumpBusy,
  output logic             loadError,
  output logic             loadDone,
  output logic [15:0]      errorRecordAddr
);
  shrl_cfg_t cfg;
  // Switch ON reads as 0 on the pins; an ON position n becomes bit n-1 set.
  assign cfg = '{baudCode:  {config_switch_value[5], config_switch_value[6],
                             config_switch_value[7]},
                 extCtlEn:  ~config_switch_value[4],
                 parityEn:  config_switch_value[3],
                 parityOdd: ~config_switch_value[2],
                 sevenBits: ~config_switch_value[1],
                 oneStop:   ~config_switch_value[0]};

  logic [19:0] bitDiv;
  logic [7:0]  onMask;
  assign onMask = ~config_switch_value;
  // Code index: bit2 = pos6 OFF, bit1 = pos7 OFF, bit0 = pos8 OFF.
  assign bitDiv = BAUD_DIV[cfg.baudCode];

  // Receiver: each bit is sampled in the middle of its period.
  logic [19:0] rxCnt;
  logic [3:0]  rxBit;
  logic [8:0]  rxShift;
  logic        rxBusy;
  logic [3:0]  rxLast;
  assign rxLast = 4'(cfg.sevenBits ? 7 : 8) + 4'(cfg.parityEn);

  logic       rxStrobe;
  logic [7:0] rxWord;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rxCnt <= '0; rxBit <= '0; rxShift <= '0; rxBusy <= 1'b0;
      rxStrobe <= 1'b0; rxWord <= '0;
      parityError <= 1'b0; framingError <= 1'b0;
    end else if (clkEn) begin
      rxStrobe <= 1'b0;
      if (!rxBusy) begin
        if (!serialIn) begin
          rxBusy <= 1'b1;
          rxBit  <= '0;
          rxCnt  <= {1'b0, bitDiv[19:1]};
        end
      end else if (rxCnt == '0) begin
        rxCnt <= bitDiv;
        if (rxBit == '0 && serialIn) begin
          rxBusy <= 1'b0;
        end else if (rxBit == rxLast + 4'd1) begin
          rxBusy   <= 1'b0;
          rxStrobe <= 1'b1;
          rxWord   <= cfg.sevenBits ? {1'b0, rxShift[8-cfg.parityEn -: 7]}
                                    : (cfg.parityEn ? rxShift[7:0]
                                                    : rxShift[8:1]);
          framingError <= !serialIn;
          // Data and parity bits together must show the selected sense.
          parityError  <= cfg.parityEn &&
                          ((cfg.sevenBits ? ^rxShift[8:1] : ^rxShift[8:0])
                           != cfg.parityOdd);
        end else begin
          if (rxBit != '0) begin
            rxShift <= {serialIn, rxShift[8:1]};
          end
          rxBit <= rxBit + 4'd1;
        end
      end else begin
        rxCnt <= rxCnt - 20'd1;
      end
    end
  end

  // Received bytes wait in the FIFO; a full FIFO drops clear-to-send.
  logic [7:0] fifoData;
  logic       fifoValid;
  logic       fifoReady;
  logic       fifoInReady;
  logic       loadBusy;
  shrl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clkEn   (clkEn),
    .inData  (rxWord),
    .inValid (rxStrobe),
    .inReady (fifoInReady),
    .outData (fifoData),
    .outValid(fifoValid),
    .outReady(fifoReady)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clearToSend_n <= 1'b1;
    end else if (clkEn) begin
      // Granted only while the host asserts request (low inside).
      clearToSend_n <= !((!reqToSend_n) && fifoInReady);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rxChar <= '0; rxCharValid <= 1'b0; external_control_mode <= 1'b0;
      switchReport <= '0;
    end else if (clkEn) begin
      switchReport <= onMask;
      rxCharValid  <= fifoValid && fifoReady;
      if (fifoValid && fifoReady) begin
        rxChar <= fifoData;
        if (cfg.extCtlEn && fifoData == CH_UPPER_C && !loadBusy) begin
          external_control_mode <= 1'b1;
        end
      end
    end
  end

  // Record parser: hex digits arrive high digit first.
  shrl_state_t state;
  logic [3:0]  nib;
  logic        isHex;
  logic        hiHalf;
  logic [7:0]  hiNib;
  logic [2:0]  fieldIdx;
  logic [7:0]  count;
  logic [15:0] recAddr;
  logic [7:0]  recType;
  logic [7:0]  sum;
  logic [15:0] segVal;
  logic [19:0] segBase;
  logic [19:0] absAddr;
  logic [7:0]  byteVal;
  logic        byteDone;
  logic        pendWr;

  assign loadBusy  = state != SHRL_IDLE && state != SHRL_DONE &&
                     state != SHRL_ERR;
  assign fifoReady = !pendWr;
  assign isHex = (fifoData >= 8'h30 && fifoData <= 8'h39) ||
                 (fifoData >= 8'h41 && fifoData <= 8'h46) ||
                 (fifoData >= 8'h61 && fifoData <= 8'h66);
  assign nib = fifoData <= 8'h39 ? 4'(fifoData - 8'h30)
                                  : 4'(fifoData[3:0] + 4'd9);
  assign byteVal  = {hiNib[3:0], nib};
  assign byteDone = fifoValid && fifoReady && isHex && !hiHalf;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= SHRL_IDLE; hiHalf <= 1'b1; hiNib <= '0; fieldIdx <= '0;
      count <= '0; recAddr <= '0; recType <= '0; sum <= '0;
      segBase <= ADDR_ZERO; absAddr <= ADDR_ZERO;
      loadError <= 1'b0; loadDone <= 1'b0; errorRecordAddr <= '0;
      segVal <= '0;
    end else if (clkEn && fifoValid && fifoReady) begin
      if (binaryMode) begin
        absAddr <= absAddr + 20'd1;
      end else if (fifoData == CH_COLON && !loadBusy) begin
        state <= SHRL_CNT; hiHalf <= 1'b1; sum <= '0; fieldIdx <= '0;
        loadDone <= 1'b0;
      end else if (loadBusy && !isHex) begin
        state <= SHRL_ERR; loadError <= 1'b1;
        errorRecordAddr <= recAddr;
      end else if (loadBusy) begin
        hiHalf <= !hiHalf;
        hiNib  <= {4'h0, nib};
        if (byteDone) begin
          sum <= sum + byteVal;
          fieldIdx <= fieldIdx + 3'd1;
          unique case (state)
            SHRL_CNT: begin
              count <= byteVal; state <= SHRL_ADDR; fieldIdx <= '0;
            end
            SHRL_ADDR: begin
              recAddr <= {recAddr[7:0], byteVal};
              if (fieldIdx == 3'd1) state <= SHRL_TYPE;
            end
            SHRL_TYPE: begin
              recType <= byteVal;
              absAddr <= segBase + {4'h0, recAddr};
              fieldIdx <= '0;
              state <= count == '0 ? SHRL_SUM : SHRL_DATA;
            end
            SHRL_DATA: begin
              if (recType == REC_SEG) segVal <= {segVal[7:0], byteVal};
              if (recType == REC_DATA) absAddr <= absAddr + 20'd1;
              count <= count - 8'd1;
              if (count == 8'd1) state <= SHRL_SUM;
            end
            SHRL_SUM: begin
              if (sum + byteVal != 8'h00) begin
                state <= SHRL_ERR; loadError <= 1'b1;
                errorRecordAddr <= recAddr;
              end else begin
                state <= recType == REC_EOF ? SHRL_DONE : SHRL_IDLE;
                loadDone <= recType == REC_EOF;
                if (recType == REC_SEG) begin
                  segBase <= {segVal, 4'h0};
                end
              end
            end
            default: state <= SHRL_IDLE;
          endcase
        end
      end
    end
  end

  // Writes hold the FIFO while the RAM stalls, so the FIFO fills back.
  logic [19:0] wrAddr;
  logic        wrEn;
  assign wrAddr = binaryMode ? absAddr + binaryOffset : absAddr;
  assign wrEn = binaryMode ||
                (state == SHRL_DATA && byteDone && recType == REC_DATA);
  assign pendWr = ramWriteValid && !ramWriteReady;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ramWrite <= '0; ramWriteValid <= 1'b0;
    end else if (clkEn) begin
      if (ramWriteValid && ramWriteReady) ramWriteValid <= 1'b0;
      if (fifoValid && fifoReady && wrEn) begin
        ramWriteValid <= 1'b1;
        ramWrite.bank <= wrAddr[19:16] & bankMask;
        ramWrite.data <= binaryMode ? fifoData : byteVal;
        ramWrite.addr <= sixteenBitMode
                         ? {~wrAddr[0], wrAddr[15:1]}
                         : wrAddr[15:0];
      end
    end
  end

  // Transmitter for the self-test characters and for dumps.
  logic [19:0] txCnt;
  logic [3:0]  txBit;
  logic [11:0] txShift;
  logic        txBusy;
  logic [7:0]  txByte;
  logic        txLoad;
  logic [19:0] dumpLeft;
  logic        sendZ;
  logic [3:0]  txFrameLen;
  assign txFrameLen = 4'd1 + (cfg.sevenBits ? 4'd7 : 4'd8) +
                      4'(cfg.parityEn) + (cfg.oneStop ? 4'd1 : 4'd2);

  assign txLoad = !txBusy && !reqToSend_n && !rxBusy &&
                  (selfTestSend || dumpBusy || sendZ);
  assign txByte = selfTestSend ? CH_UPPER_A
                : (dumpBusy ? dumpReadData : CH_CTRL_Z);

  logic       par;
  assign par = (cfg.sevenBits ? ^txByte[6:0] : ^txByte) ^ cfg.parityOdd;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txCnt <= '0; txBit <= '0; txShift <= '1; txBusy <= 1'b0;
      serialOut <= 1'b1;
    end else if (clkEn) begin
      if (txLoad) begin
        txBusy <= 1'b1; txBit <= '0; txCnt <= bitDiv;
        txShift <= cfg.sevenBits
          ? (cfg.parityEn ? {3'b111, par, txByte[6:0], 1'b0}
                          : {4'b1111, txByte[6:0], 1'b0})
          : (cfg.parityEn ? {2'b11, par, txByte, 1'b0}
                          : {3'b111, txByte, 1'b0});
        serialOut <= 1'b0;
      end else if (txBusy) begin
        if (txCnt == '0) begin
          txCnt <= bitDiv;
          txBit <= txBit + 4'd1;
          txShift <= {1'b1, txShift[11:1]};
          serialOut <= txShift[1];
          if (txBit == txFrameLen - 4'd1) begin
            txBusy <= 1'b0; serialOut <= 1'b1;
          end
        end else begin
          txCnt <= txCnt - 20'd1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dumpBusy <= 1'b0; dumpReadAddr <= ADDR_ZERO; dumpLeft <= '0;
      sendZ <= 1'b0;
    end else if (clkEn) begin
      if (dumpStart && !dumpBusy) begin
        dumpBusy <= 1'b1;
        dumpReadAddr <= socket1_start_address;
        // Only the colon-hex format may exceed 64K bytes.
        dumpLeft <= (!dumpHexFormat && dumpLength > 20'h10000)
                    ? 20'h10000 : dumpLength;
      end else if (txLoad && dumpBusy) begin
        dumpReadAddr <= dumpReadAddr + 20'd1;
        dumpLeft <= dumpLeft - 20'd1;
        if (dumpLeft == 20'd1) begin
          dumpBusy <= 1'b0; sendZ <= 1'b1;
        end
      end else if (txLoad && sendZ) begin
        sendZ <= 1'b0;
      end
    end
  end

  // The last dump byte must hand over to the closing control-Z.
  sequence s_last_dump_byte;
    clkEn && txLoad && dumpBusy && dumpLeft == 20'd1;
  endsequence

  a_cts_follows_rts: assert property (
    @(posedge sys_clk) disable iff (reset)
    clkEn && reqToSend_n |=> clearToSend_n)
    else $error("clear-to-send granted without request");
  a_cts_when_full: assert property (
    @(posedge sys_clk) disable iff (reset)
    clkEn && !fifoInReady |=> clearToSend_n)
    else $error("clear-to-send granted while receive buffer full");
  a_no_echo_rx: assert property (
    @(posedge sys_clk) disable iff (reset)
    rxBusy |-> !txLoad)
    else $error("transmit started while receiving");
  a_tx_no_source: assert property (
    @(posedge sys_clk) disable iff (reset)
    clkEn && !txBusy && !selfTestSend && !dumpBusy && !sendZ
    |=> !txBusy)
    else $error("transmit started without a source");
  a_ctrlz_after_dump: assert property (
    @(posedge sys_clk) disable iff (reset)
    s_last_dump_byte |=> sendZ && !dumpBusy)
    else $error("control-Z not queued after last dump byte");
  a_bank_trunc: assert property (
    @(posedge sys_clk) disable iff (reset)
    ramWriteValid |-> (ramWrite.bank & ~bankMask) == 4'h0)
    else $error("bank not truncated");
  a_switch_rep: assert property (
    @(posedge sys_clk) disable iff (reset)
    clkEn |=> switchReport == ~$past(config_switch_value))
    else $error("switch report wrong");
endmodule : shrl_loader

// ### design/shrl_pkg.sv
package shrl_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FIFO_WIDTH  = 8;
  localparam logic [7:0]  CH_COLON    = 8'h3a;
  localparam logic [7:0]  CH_UPPER_A  = 8'h41;
  localparam logic [7:0]  CH_UPPER_C  = 8'h43;
  localparam logic [7:0]  CH_CTRL_Z   = 8'h1a;
  localparam logic [7:0]  REC_DATA    = 8'h00;
  localparam logic [7:0]  REC_EOF     = 8'h01;
  localparam logic [7:0]  REC_SEG     = 8'h02;
  localparam logic [7:0]  REC_START   = 8'h03;
  localparam logic [3:0]  BANK_MASK_RST = 4'h1;
  localparam logic [19:0] ADDR_ZERO   = 20'h00000;
  // Bit-period divisors (sys_clk cycles), indexed by switch code {p6,p7,p8}
  // with OFF = 1; 110 baud is code 0.
  localparam logic [19:0] BAUD_DIV [8] = '{
    20'(CLK_HZ / 110),  20'(CLK_HZ / 150),  20'(CLK_HZ / 300),
    20'(CLK_HZ / 1200), 20'(CLK_HZ / 2400), 20'(CLK_HZ / 4800),
    20'(CLK_HZ / 9600), 20'(CLK_HZ / 19200)};

  typedef struct packed {
    logic [3:0]  bank;
    logic [15:0] addr;
    logic [7:0]  data;
  } shrl_wr_t;

  typedef struct packed {
    logic [2:0] baudCode;
    logic       extCtlEn;
    logic       parityEn;
    logic       parityOdd;
    logic       sevenBits;
    logic       oneStop;
  } shrl_cfg_t;

  typedef enum logic [3:0] {
    SHRL_IDLE  = 4'b0000,
    SHRL_CNT   = 4'b0001,
    SHRL_ADDR  = 4'b0011,
    SHRL_TYPE  = 4'b0010,
    SHRL_DATA  = 4'b0110,
    SHRL_SUM   = 4'b0111,
    SHRL_DONE  = 4'b0101,
    SHRL_ERR   = 4'b0100
  } shrl_state_t;
endpackage : shrl_pkg

// ### design/shrl_fifo.sv
`timescale 1ns/1ps
module shrl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push     = clkEn && inValid && inReady;
  assign pop      = clkEn && outValid && outReady;
  assign inReady  = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData  = mem[rdPtr];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : shrl_fifo

// ### verification/shrl_term_model.sv
`timescale 1ns/1ps
module shrl_term_model #(
  parameter int BIT_CYC = 2083
) (
  input  wire logic sys_clk,
  input  wire logic txLine,
  output logic      rxLine,
  output logic      reqToSend_n,
  input  wire logic clearToSend_n,
  input  wire logic rtsDrop,
  input  wire logic parityEn,
  input  wire logic parityOdd,
  input  wire logic sevenBits,
  input  wire logic badParity
);
  logic [7:0] rxQ[$];

  // Without handshaking the request line is looped to asserted (low).
  assign reqToSend_n = rtsDrop;

  initial rxLine = 1'b1;

  task automatic bit_wait;
    repeat (BIT_CYC) @(negedge sys_clk);
  endtask : bit_wait

  task automatic send_char(input logic [7:0] c);
    int   n;
    logic p;
    n = sevenBits ? 7 : 8;
    p = parityOdd ^ badParity;
    while (clearToSend_n !== 1'b0) @(negedge sys_clk);
    rxLine = 1'b0;
    bit_wait();
    for (int i = 0; i < n; i++) begin
      rxLine = c[i];
      p = p ^ c[i];
      bit_wait();
    end
    if (parityEn) begin
      rxLine = p;
      bit_wait();
    end
    rxLine = 1'b1;
    bit_wait();
  endtask : send_char

  // A bad stop bit is queued as ff, which no 7-bit character can be.
  initial begin : rx_proc
    logic [7:0] c;
    forever begin
      @(negedge sys_clk);
      if (txLine === 1'b0) begin
        repeat (BIT_CYC / 2) @(negedge sys_clk);
        c = 8'h00;
        for (int i = 0; i < (sevenBits ? 7 : 8); i++) begin
          bit_wait();
          c[i] = txLine;
        end
        if (parityEn) bit_wait();
        bit_wait();
        rxQ.push_back((txLine === 1'b1) ? c : 8'hff);
      end
    end
  end
endmodule : shrl_term_model

// ### verification/shrl_loader_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module shrl_loader_tb
  import shrl_pkg::*;
;
  localparam int BIT_CYC  = CLK_HZ / 19200;
  localparam int CHAR_CYC = BIT_CYC * 11;
  localparam int LIMIT    = 700000;

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        serialIn;
  logic        serialOut;
  logic        reqToSend_n;
  logic        clkEn = 1'b1;
  logic [3:0]  bankMask = 4'h1;
  logic        clearToSend_n;
  logic [7:0]  sw = 8'he4;
  logic        sixteenBitMode = 1'b0;
  logic        selfTestSend = 1'b0;
  logic        dumpStart = 1'b0;
  logic [19:0] socket1 = 20'h12340;
  logic [19:0] dumpLength = 20'h00001;
  logic [7:0]  switchReport;
  logic [7:0]  rxChar;
  logic        rxCharValid;
  logic        parityError;
  logic        framingError;
  logic        extCtl;
  shrl_wr_t    ramWrite;
  logic        ramWriteValid;
  logic        ramWriteReady = 1'b1;
  logic [19:0] dumpReadAddr;
  logic [7:0]  dumpReadData;
  logic        dumpBusy;
  logic        loadError;
  logic        loadDone;
  logic [15:0] errorRecordAddr;
  logic        rtsDrop = 1'b0;
  logic        badPar = 1'b0;
  logic        txPrev = 1'b1;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          rxCnt = 0;
  int          txFalls = 0;
  logic [7:0]  lastRx;
  shrl_wr_t    wrQ[$];

  // The buffer RAM answers with a value tied to the address it is given.
  assign dumpReadData = dumpReadAddr[7:0] ^ 8'h55;

  always #12.5 sys_clk = ~sys_clk;

  shrl_loader u_dut (
    .sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
    .serialIn(serialIn), .serialOut(serialOut),
    .reqToSend_n(reqToSend_n), .clearToSend_n(clearToSend_n),
    .config_switch_value(sw), .sixteenBitMode(sixteenBitMode),
    .binaryMode(1'b0), .binaryOffset(20'h00000), .bankMask(bankMask),
    .selfTestSend(selfTestSend), .dumpStart(dumpStart),
    .dumpHexFormat(1'b1), .socket1_start_address(socket1),
    .dumpLength(dumpLength), .switchReport(switchReport),
    .rxChar(rxChar), .rxCharValid(rxCharValid),
    .parityError(parityError), .framingError(framingError),
    .external_control_mode(extCtl), .ramWrite(ramWrite),
    .ramWriteValid(ramWriteValid), .ramWriteReady(ramWriteReady),
    .dumpReadAddr(dumpReadAddr), .dumpReadData(dumpReadData),
    .dumpBusy(dumpBusy), .loadError(loadError), .loadDone(loadDone),
    .errorRecordAddr(errorRecordAddr)
  );

  shrl_term_model #(.BIT_CYC(BIT_CYC)) u_term (
    .sys_clk(sys_clk), .txLine(serialOut), .rxLine(serialIn),
    .reqToSend_n(reqToSend_n), .clearToSend_n(clearToSend_n),
    .rtsDrop(rtsDrop), .parityEn(sw[3]), .parityOdd(~sw[2]),
    .sevenBits(~sw[1]), .badParity(badPar)
  );

  always @(posedge sys_clk) begin
    cycles++;
    if (rxCharValid === 1'b1) begin
      rxCnt++;
      lastRx = rxChar;
    end
    if (ramWriteValid === 1'b1 && ramWriteReady === 1'b1) begin
      wrQ.push_back(ramWrite);
    end
    if (serialOut === 1'b0 && txPrev === 1'b1) txFalls++;
    txPrev = serialOut;
    if (cycles == LIMIT) begin
      error_cnt++;
      final_report();
    end
  end

  task final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task do_reset(input logic [7:0] s);
    @(negedge sys_clk);
    sw = s;
    reset = 1'b1;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
  endtask : do_reset

  task wait_q(input int n);
    for (int k = 0; k < 3 * n * CHAR_CYC && u_term.rxQ.size() < n; k++)
      @(negedge sys_clk);
  endtask : wait_q

  task send_str(input string s);
    for (int i = 0; i < s.len(); i++) u_term.send_char(s[i]);
  endtask : send_str

  task t_idle;
    `CHK("serialOut idle", 1'b1, serialOut);
    `CHK("switchReport", 8'h1b, switchReport);
    `CHK("extCtl at reset", 1'b0, extCtl);
  endtask : t_idle

  // A low clock enable must hold the grant although the request drops.
  task t_freeze;
    clkEn = 1'b0;
    rtsDrop = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK("cts frozen", 1'b0, clearToSend_n);
    clkEn = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK("cts without request", 1'b1, clearToSend_n);
    rtsDrop = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : t_freeze

  task t_ext_ctl;
    int f;
    int n;
    f = txFalls;
    n = rxCnt;
    u_term.send_char(CH_UPPER_C);
    for (int k = 0; k < 64 && rxCnt == n; k++) @(negedge sys_clk);
    `CHK("rxChar", CH_UPPER_C, lastRx);
    `CHK("extCtl", 1'b1, extCtl);
    `CHK("no echo", f, txFalls);
  endtask : t_ext_ctl

  task t_self_test;
    int f;
    rtsDrop = 1'b1;
    selfTestSend = 1'b1;
    f = txFalls;
    repeat (CHAR_CYC) @(negedge sys_clk);
    `CHK("tx held without request", f, txFalls);
    u_term.rxQ.delete();
    rtsDrop = 1'b0;
    wait_q(2);
    `CHK("self test char 0", CH_UPPER_A, u_term.rxQ[0]);
    `CHK("self test char 1", CH_UPPER_A, u_term.rxQ[1]);
    selfTestSend = 1'b0;
    repeat (CHAR_CYC) @(negedge sys_clk);
    u_term.rxQ.delete();
  endtask : t_self_test

  // The first byte sent proves the read began at the socket 1 address.
  task t_dump;
    dumpStart = 1'b1;
    @(negedge sys_clk);
    dumpStart = 1'b0;
    wait_q(2);
    `CHK("dump byte", socket1[7:0] ^ 8'h55, u_term.rxQ[0]);
    `CHK("dump end char", CH_CTRL_Z, u_term.rxQ[1]);
    `CHK("dumpBusy done", 1'b0, dumpBusy);
  endtask : t_dump

  task t_record16;
    logic [15:0] a;
    logic [7:0]  cs;
    a = 16'h4567;
    cs = 8'h00 - (8'h01 + a[15:8] + a[7:0] + REC_DATA + 8'ha1);
    sixteenBitMode = 1'b1;
    ramWriteReady = 1'b0;
    wrQ.delete();
    send_str($sformatf(":01%04X%02X%02X%02X", a, REC_DATA, 8'ha1,
                       cs));
    for (int k = 0; k < CHAR_CYC && ramWriteValid !== 1'b1; k++)
      @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    `CHK("write held while stalled", 1'b1, ramWriteValid);
    ramWriteReady = 1'b1;
    for (int k = 0; k < 16 && wrQ.size() == 0; k++) @(negedge sys_clk);
    `CHK("write count", 1, wrQ.size());
    `CHK("bank", 4'h0, wrQ[0].bank);
    `CHK("split addr", {~a[0], a[15:1]}, wrQ[0].addr);
    `CHK("data", 8'ha1, wrQ[0].data);
    repeat (8) @(negedge sys_clk);
    `CHK("no load error", 1'b0, loadError);
  endtask : t_record16

  task t_bad_hex;
    send_str(":G");
    repeat (64) @(negedge sys_clk);
    `CHK("loadError on bad digit", 1'b1, loadError);
  endtask : t_bad_hex

  task t_parity;
    int n;
    do_reset(8'hec);
    n = rxCnt;
    badPar = 1'b1;
    u_term.send_char(8'h55);
    badPar = 1'b0;
    for (int k = 0; k < 64 && rxCnt == n; k++) @(negedge sys_clk);
    `CHK("parityError", 1'b1, parityError);
    `CHK("framingError", 1'b0, framingError);
  endtask : t_parity

  initial begin
    do_reset(8'he4);
    t_idle();
    t_freeze();
    t_ext_ctl();
    t_self_test();
    t_dump();
    t_record16();
    t_bad_hex();
    t_parity();
    final_report();
  end
endmodule : shrl_loader_tb
